// *** common/prm_pkg.sv ***
// Constants, modes and carrier structs for the priority request manager.
// Assumes one clock domain and synchronous request and control inputs.
package prm_pkg;
   // ------------------------------------------------------------
   // Sizes and reset values
   // ------------------------------------------------------------
   localparam int unsigned NUM_REQ = 8;        // Request inputs per controller
   localparam int unsigned LVL_W = 3;          // Width of a level number
   localparam logic [2:0] LOWEST_RST = 3'h7;   // Bottom level after reset
   localparam logic [2:0] NESTED_LOWEST = 3'h7; // Fixed bottom level when nested
   localparam logic [7:0] CALL_OPCODE = 8'hcd; // Call opcode sent on first ack
   localparam int unsigned VEC_SHIFT = 2;      // Routine spacing is 4 bytes
   localparam int unsigned POLL_VALID_BIT = 7; // Poll word: request present flag
   localparam logic [7:0] DATA_RST = 8'h00;    // Data bus value at reset

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {PRM_NESTED, PRM_ROTATE, PRM_SPECIFIC} prm_mode_t;

   // Static configuration, may change at any cycle
   typedef struct packed {
      logic [7:0] mask;       // One bit per input, 1 blocks it
      prm_mode_t mode;        // Priority mode
      logic [7:0] slave_map;  // Inputs fed by a cascaded slave
      logic is_slave;         // This controller is a slave
      logic [2:0] cas_id;     // Slave identity on the cascade code
      logic [15:0] vec_base;  // Address of routine for level 0
   } prm_cfg_t;

   // One-cycle software commands
   typedef struct packed {
      logic eoi;              // End of service for top in-service level
      logic spec_load;        // Load bottom level (specific mode)
      logic [2:0] spec_level; // Level to become the bottom
      logic poll_rd;          // Polled read of the winner
   } prm_cmd_t;
endpackage

// *** rtl/prm_core.sv ***
// Priority request manager: eight-level vectored interrupt controller.
// Assumes requests, acknowledge and commands are synchronous to clock_in.
`timescale 1ns/100ps
module prm_core
(
   input wire logic clock_in,
   input wire logic rst_n_in,
   input wire logic [7:0] req_in,
   input wire prm_pkg::prm_cfg_t cfg_in,
   input wire prm_pkg::prm_cmd_t cmd_in,
   input wire logic inta_in,
   input wire logic [2:0] cas_in,
   output logic int_out,
   output logic [7:0] data_out,
   output logic data_oe_out,
   output logic [2:0] cas_out,
   output logic cas_oe_out
);
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // Scan from the level just above the bottom; returns {found, level}
   function automatic logic [3:0] pick(input logic [7:0] vec, input logic [2:0] low);
      logic [3:0] res;
      logic [2:0] idx;
      res = 4'h0;
      for (int r = 7; r >= 0; r--)
      begin
         idx = low + 3'(r + 1);
         if (vec[idx])
            res = {1'b1, idx};
      end
      return res;
   endfunction

   // Rank 0 is the top priority
   function automatic logic [2:0] rank(input logic [2:0] lvl, input logic [2:0] low);
      return 3'(lvl - low - 3'h1);
   endfunction

   typedef enum logic [1:0] {PRM_IDLE, PRM_LOW, PRM_HIGH} prm_ack_t;

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   prm_ack_t ack_q, ack_d;           // Acknowledge sequence position
   logic [7:0] isr_q, isr_d;         // In-service levels
   logic [2:0] lowest_q, lowest_d;   // Bottom level for rotating modes
   logic [2:0] lvl_q, lvl_d;         // Level latched at first ack
   logic int_q, int_d;
   logic [7:0] data_q, data_d;
   logic oe_q, oe_d;
   logic [2:0] cas_q, cas_d;
   logic cas_oe_q, cas_oe_d;
   logic inta_prev_q;                // For rising edge of acknowledge

   // ------------------------------------------------------------
   // Priority resolution
   // ------------------------------------------------------------
   wire logic [7:0] pending = req_in & ~cfg_in.mask;
   // Nested mode ignores the stored bottom, so a mode change needs no reinit
   wire logic [2:0] low_eff = (cfg_in.mode == prm_pkg::PRM_NESTED) ? prm_pkg::NESTED_LOWEST : lowest_q;
   wire logic [3:0] req_pick = pick(pending, low_eff);
   wire logic [3:0] isr_pick = pick(isr_q, low_eff);
   wire logic req_found = req_pick[3];
   wire logic [2:0] win = req_pick[2:0];
   wire logic isr_found = isr_pick[3];
   wire logic [2:0] top_isr = isr_pick[2:0];
   // Equal rank does not preempt: a level cannot nest on itself
   wire logic outranks = !isr_found || (rank(win, low_eff) < rank(top_isr, low_eff));
   wire logic int_cond = req_found && outranks;
   wire logic inta_rise = inta_in && !inta_prev_q;
   wire logic first_ack = inta_rise && (ack_q == PRM_IDLE);
   // Spurious ack with nothing pending answers for the bottom level
   wire logic [2:0] ack_lvl = req_found ? win : low_eff;
   wire logic via_slave = !cfg_in.is_slave && cfg_in.slave_map[lvl_q];
   wire logic selected = cfg_in.is_slave ? (cas_in == cfg_in.cas_id) : !via_slave;
   wire logic [15:0] vec_addr = cfg_in.vec_base + (16'(lvl_q) << prm_pkg::VEC_SHIFT);
   wire logic slave_mark = cfg_in.is_slave && inta_rise && (ack_q == PRM_LOW) && selected;
   wire logic master_mark = !cfg_in.is_slave && first_ack && req_found;
   // A poll that meets a first ack is answered by the ack, so it marks nothing itself
   wire logic poll_mark = cmd_in.poll_rd && req_found && (ack_q == PRM_IDLE) && !first_ack;

   // ------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------
   // Sequencer, in-service bits, bottom level and bus drive
   always_comb
   begin
      ack_d = ack_q;
      isr_d = isr_q;
      lowest_d = lowest_q;
      lvl_d = lvl_q;
      data_d = data_q;
      oe_d = oe_q && inta_in;       // Release bus once the ack ends
      cas_d = cas_q;
      cas_oe_d = cas_oe_q;
      // End of service clears the top in-service level
      if (cmd_in.eoi && isr_found)
      begin
         isr_d[top_isr] = 1'b0;
         if (cfg_in.mode != prm_pkg::PRM_NESTED)
            lowest_d = top_isr;
      end
      if (cmd_in.spec_load && cfg_in.mode == prm_pkg::PRM_SPECIFIC)
         lowest_d = cmd_in.spec_level;
      // Marking after the clear keeps a fresh ack from being lost
      if (master_mark)
         isr_d[win] = 1'b1;
      if (slave_mark)
         isr_d[lvl_q] = 1'b1;
      if (poll_mark)
         isr_d[win] = 1'b1;
      case (ack_q)
         PRM_IDLE:
         begin
            if (first_ack)
            begin
               // A slave keeps off the bus for the opcode
               ack_d = PRM_LOW;
               lvl_d = ack_lvl;
               data_d = prm_pkg::CALL_OPCODE;
               oe_d = !cfg_in.is_slave;
               cas_d = ack_lvl;
               cas_oe_d = !cfg_in.is_slave && cfg_in.slave_map[ack_lvl];
            end
            else if (cmd_in.poll_rd)
            begin
               data_d = {req_found, 4'h0, win};
               oe_d = 1'b1;
            end
         end
         PRM_LOW:
         begin
            if (inta_rise)
            begin
               ack_d = PRM_HIGH;
               data_d = vec_addr[7:0];
               oe_d = selected;
            end
         end
         PRM_HIGH:
         begin
            if (inta_rise)
            begin
               ack_d = PRM_IDLE;
               data_d = vec_addr[15:8];
               oe_d = selected;
               cas_oe_d = 1'b0;
            end
         end
         default:
            ack_d = PRM_IDLE;
      endcase
      // Interrupt line drops while an ack sequence runs
      int_d = int_cond && (ack_d == PRM_IDLE) && !first_ack;
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   // All state on one clock, asynchronous reset to constants
   always_ff @(posedge clock_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         ack_q <= PRM_IDLE;
         isr_q <= 8'h00;
         lowest_q <= prm_pkg::LOWEST_RST;
         lvl_q <= 3'h0;
         int_q <= 1'b0;
         data_q <= prm_pkg::DATA_RST;
         oe_q <= 1'b0;
         cas_q <= 3'h0;
         cas_oe_q <= 1'b0;
         inta_prev_q <= 1'b0;
      end
      else
      begin
         ack_q <= ack_d;
         isr_q <= isr_d;
         lowest_q <= lowest_d;
         lvl_q <= lvl_d;
         int_q <= int_d;
         data_q <= data_d;
         oe_q <= oe_d;
         cas_q <= cas_d;
         cas_oe_q <= cas_oe_d;
         inta_prev_q <= inta_in;
      end
   end

   assign int_out = int_q;
   assign data_out = data_q;
   assign data_oe_out = oe_q;
   assign cas_out = cas_q;
   assign cas_oe_out = cas_oe_q;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   property p_masked_quiet;
      @(posedge clock_in) disable iff (!rst_n_in) (pending == 8'h00) |=> !int_out;
   endproperty
   a_masked_quiet: assert property (p_masked_quiet) else $error("interrupt with no unmasked request");

   property p_no_preempt;
      @(posedge clock_in) disable iff (!rst_n_in)
         (req_found && isr_found && rank(win, low_eff) >= rank(top_isr, low_eff)) |=> !int_out;
   endproperty
   a_no_preempt: assert property (p_no_preempt) else $error("lower request preempted service");

   property p_raise;
      @(posedge clock_in) disable iff (!rst_n_in)
         (ack_q == PRM_IDLE && !inta_in && !inta_prev_q && req_found && !isr_found) |=> int_out;
   endproperty
   a_raise: assert property (p_raise) else $error("pending request did not interrupt");

   property p_opcode;
      @(posedge clock_in) disable iff (!rst_n_in)
         (first_ack && !cfg_in.is_slave) |=> (data_out == prm_pkg::CALL_OPCODE) && data_oe_out;
   endproperty
   a_opcode: assert property (p_opcode) else $error("call opcode missing on first ack");

   // A slave leaves the opcode byte to the master
   property p_slave_quiet;
      @(posedge clock_in) disable iff (!rst_n_in) (first_ack && cfg_in.is_slave) |=> !data_oe_out;
   endproperty
   a_slave_quiet: assert property (p_slave_quiet) else $error("slave drove the opcode byte");

   property p_low_byte;
      @(posedge clock_in) disable iff (!rst_n_in)
         (inta_rise && ack_q == PRM_LOW) |=> (data_out == $past(vec_addr[7:0])) && (ack_q == PRM_HIGH);
   endproperty
   a_low_byte: assert property (p_low_byte) else $error("low address byte wrong");

   property p_mark;
      @(posedge clock_in) disable iff (!rst_n_in) master_mark |=> isr_q[lvl_q] && (lvl_q == $past(win));
   endproperty
   a_mark: assert property (p_mark) else $error("acknowledged level not in service");

   property p_rotate;
      @(posedge clock_in) disable iff (!rst_n_in)
         (cmd_in.eoi && isr_found && cfg_in.mode == prm_pkg::PRM_ROTATE && !cmd_in.spec_load)
         |=> (lowest_q == $past(top_isr));
   endproperty
   a_rotate: assert property (p_rotate) else $error("serviced level not moved to bottom");

   property p_specific;
      @(posedge clock_in) disable iff (!rst_n_in)
         (cmd_in.spec_load && cfg_in.mode == prm_pkg::PRM_SPECIFIC) |=> (lowest_q == $past(cmd_in.spec_level));
   endproperty
   a_specific: assert property (p_specific) else $error("bottom level not loaded");

   property p_poll;
      @(posedge clock_in) disable iff (!rst_n_in)
         (cmd_in.poll_rd && !first_ack && ack_q == PRM_IDLE)
         |=> data_oe_out && (data_out[2:0] == $past(win)) && (data_out[prm_pkg::POLL_VALID_BIT] == $past(req_found));
   endproperty
   a_poll: assert property (p_poll) else $error("poll word wrong");

   property p_nested_top;
      @(posedge clock_in) disable iff (!rst_n_in)
         (cfg_in.mode == prm_pkg::PRM_NESTED && pending[0]) |-> (win == 3'h0);
   endproperty
   a_nested_top: assert property (p_nested_top) else $error("input 0 not top in nested mode");

   c_full_call: cover property (@(posedge clock_in) disable iff (!rst_n_in)
      (ack_q == PRM_HIGH) ##1 (ack_q == PRM_IDLE));
   c_nest: cover property (@(posedge clock_in) disable iff (!rst_n_in) isr_found ##1 int_out);
   c_rotate: cover property (@(posedge clock_in) disable iff (!rst_n_in)
      cmd_in.eoi && cfg_in.mode == prm_pkg::PRM_ROTATE && isr_found);
   c_poll: cover property (@(posedge clock_in) disable iff (!rst_n_in) poll_mark);
endmodule

// *** verif/prm_cpu_model.sv ***
// Processor model: answers the interrupt line with a three-acknowledge call.
// Assumes it is clocked with the core and its outputs change on falling edges.
`timescale 1ns/100ps
module prm_cpu_model
(
   input wire logic clock_in,
   input wire logic int_in,
   input wire logic [7:0] data_in,
   input wire logic data_oe_in,
   input wire logic en_in,
   input wire logic slow_in,
   output logic inta_out,
   output logic [23:0] call_out,
   output int seq_count_out
);
   // ------------------------------------------------------------
   // Acknowledge sequencer
   // ------------------------------------------------------------
   // One process owns every output, so each has a single driver
   initial
   begin
      inta_out = 1'b0;
      call_out = 24'h000000;
      seq_count_out = 0;
      // Each acknowledge is held across the answer edge, then the byte is taken
      forever
      begin
         @(negedge clock_in);
         if (en_in && int_in)
         begin
            for (int k = 0; k < 3; k++)
            begin
               inta_out = 1'b1;
               repeat (2) @(negedge clock_in);
               // An undriven bus reads inverted so a missing enable cannot pass
               call_out = {call_out[15:0], data_oe_in ? data_in : ~data_in};
               inta_out = 1'b0;
               repeat (1 + 3 * slow_in) @(negedge clock_in);
            end
            seq_count_out++;
            // One call per enable, so the bench decides when the next may start
            wait (!en_in);
         end
      end
   end
endmodule

// *** verif/prm_core_tb_top.sv ***
// Self-checking bench for the priority request manager core.
// Assumes the processor model answers one interrupt each time it is enabled.
`timescale 1ns/100ps
module prm_core_tb_top;
   // ------------------------------------------------------------
   // Stimulus, design and partner
   // ------------------------------------------------------------
   logic clock_in = 1'b0; // 125 MHz clock
   logic rst_n_in = 1'b0; // Reset held at start
   logic [7:0] req = 8'h00; // Request lines
   prm_pkg::prm_cfg_t cfg = '0; // Live configuration, nested mode
   prm_pkg::prm_cmd_t cmd = '0; // Command pulses
   logic cpu_en = 1'b0; // Lets the model acknowledge
   logic cpu_slow = 1'b0; // Stretches gaps between acknowledges
   logic [2:0] cas_sel = 3'h0; // Cascade code seen when acting as a slave
   logic [23:0] call_inv = 24'h000000; // Bytes expected undriven, read inverted
   logic inta, int_w, data_oe, cas_oe;
   logic [7:0] data;
   logic [2:0] cas;
   logic [23:0] call;
   int seq_count;
   int err_total = 0;
   int check_count = 0;
   logic [31:0] rng = 32'h00012513; // Fixed seed

   always #4 clock_in = ~clock_in;

   prm_core i_dut (.clock_in(clock_in), .rst_n_in(rst_n_in), .req_in(req), .cfg_in(cfg), .cmd_in(cmd),
      .inta_in(inta), .cas_in(cas_sel), .int_out(int_w), .data_out(data), .data_oe_out(data_oe),
      .cas_out(cas), .cas_oe_out(cas_oe));

   prm_cpu_model i_cpu (.clock_in(clock_in), .int_in(int_w), .data_in(data), .data_oe_in(data_oe),
      .en_in(cpu_en), .slow_in(cpu_slow), .inta_out(inta), .call_out(call), .seq_count_out(seq_count));

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] xs();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction

   // Highest ranked active level: bottom+1 first, bottom last
   function automatic logic [2:0] winner(input logic [7:0] act, input logic [2:0] bottom);
      logic [2:0] lvl;
      winner = bottom;
      for (int k = 8; k >= 1; k--)
      begin
         lvl = bottom + 3'(k);
         if (act[lvl]) winner = lvl;
      end
   endfunction

   task automatic print_verdict();
      $display("Checks %0d, errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk_word(input logic [23:0] got, input logic [23:0] exp);
      check_count++;
      if (got !== exp)
      begin
         err_total++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_flag(input logic got, input logic exp);
      chk_word({23'h0, got}, {23'h0, exp});
   endtask

   task automatic settle(input int n);
      repeat (n) @(negedge clock_in);
   endtask

   // One-cycle command; returns at the cycle that shows its answer
   // A free edge first keeps back-to-back commands from reassigning in one step
   task automatic pulse(input logic e, input logic s, input logic [2:0] l, input logic p);
      settle(1);
      cmd = '{eoi: e, spec_load: s, spec_level: l, poll_rd: p};
      settle(1);
      cmd = '0;
   endtask

   // Let the model take one call and compare opcode and routine address
   task automatic serve(input logic [2:0] lvl);
      int c0;
      logic [15:0] a;
      logic seen;
      c0 = seq_count;
      a = cfg.vec_base + {11'h000, lvl, 2'h0};
      seen = 1'b0;
      cpu_en = 1'b1;
      // Watch the cascade enable while the call runs
      for (int i = 0; i < 80 && seq_count == c0; i++)
      begin
         settle(1);
         seen = seen | cas_oe;
      end
      cpu_en = 1'b0;
      if (seq_count == c0)
      begin
         err_total++;
         $display("ERROR at %0t: got %h expected %h", $time, seq_count, c0 + 1);
         print_verdict();
      end
      else
      begin
         chk_word(call, {prm_pkg::CALL_OPCODE, a[7:0], a[15:8]} ^ call_inv);
         chk_word({21'h0, cas}, {21'h0, lvl});
         chk_flag(seen, cfg.slave_map[lvl] && !cfg.is_slave);
      end
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial
   begin
      settle(10);
      chk_word({21'h0, int_w, data_oe, cas_oe}, 24'h000000);
      rst_n_in = 1'b1;
      // Random nested traffic with random masks and call bases
      for (int n = 0; n < 24; n++)
      begin
         cfg.mask = 8'(xs() & xs());
         cfg.vec_base = 16'(xs());
         cpu_slow = 1'(xs());
         req = 8'(xs());
         settle(3);
         chk_flag(int_w, |(req & ~cfg.mask));
         if (|(req & ~cfg.mask)) serve(winner(req & ~cfg.mask, 3'h7));
         req = 8'h00;
         pulse(1'b1, 1'b0, 3'h0, 1'b0);
         settle(2);
      end
      cfg.mask = 8'h00;
      // Nesting: lower waits, higher preempts
      req = 8'h20;
      serve(3'h5);
      req = 8'h40;
      settle(4);
      chk_flag(int_w, 1'b0);
      req = 8'h44;
      serve(3'h2);
      req = 8'h00;
      pulse(1'b1, 1'b0, 3'h0, 1'b0);
      pulse(1'b1, 1'b0, 3'h0, 1'b0);
      // Rotation: serviced level 3 drops to the bottom
      cfg.mode = prm_pkg::PRM_ROTATE;
      req = 8'h08;
      serve(3'h3);
      req = 8'h00;
      pulse(1'b1, 1'b0, 3'h0, 1'b0);
      req = 8'h11;
      serve(3'h4);
      req = 8'h00;
      pulse(1'b1, 1'b0, 3'h0, 1'b0);
      // Specific: software makes level 5 the bottom
      cfg.mode = prm_pkg::PRM_SPECIFIC;
      pulse(1'b0, 1'b1, 3'h5, 1'b0);
      req = 8'h41;
      serve(3'h6);
      req = 8'h00;
      pulse(1'b1, 1'b0, 3'h0, 1'b0);
      // Polled read, then a poll that finds only a masked input
      cfg.mode = prm_pkg::PRM_NESTED;
      req = 8'h24;
      settle(2);
      pulse(1'b0, 1'b0, 3'h0, 1'b1);
      chk_word({15'h0, data_oe, data}, 24'h000182);
      req = 8'h00;
      pulse(1'b1, 1'b0, 3'h0, 1'b0);
      cfg.mask = 8'h01;
      req = 8'h01;
      pulse(1'b0, 1'b0, 3'h0, 1'b1);
      chk_flag(data[7], 1'b0);
      settle(3);
      chk_flag(int_w, 1'b0);
      cfg.mask = 8'h00;
      settle(3);
      chk_flag(int_w, 1'b1);
      serve(3'h0);
      req = 8'h00;
      pulse(1'b1, 1'b0, 3'h0, 1'b0);
      // Cascade: master leaves bytes 2 and 3 to a slave, then this block as a slave
      cfg.slave_map = 8'h08;
      call_inv = 24'h00ffff;
      req = 8'h08;
      serve(3'h3);
      req = 8'h00;
      pulse(1'b1, 1'b0, 3'h0, 1'b0);
      cfg.slave_map = 8'h00;
      cfg.is_slave = 1'b1;
      cfg.cas_id = 3'h5;
      cas_sel = 3'h2;
      call_inv = 24'hffffff;
      req = 8'h02;
      serve(3'h1);
      settle(3);
      chk_flag(int_w, 1'b1);
      cas_sel = 3'h5;
      call_inv = 24'hff0000;
      serve(3'h1);
      req = 8'h00;
      pulse(1'b1, 1'b0, 3'h0, 1'b0);
      cfg.is_slave = 1'b0;
      call_inv = 24'h000000;
      settle(4);
      chk_flag(int_w, 1'b0);
      print_verdict();
   end
endmodule
